// File: hdl/tmr_timer.sv
// 8/16-bit timer/counter with compare, capture and cpu register access
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_timer #(
    parameter int FILT_SAMPLES = `TMR_FILT_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // cpu io port
    input wire tmr_pkg::tmr_addr_t io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire tmr_pkg::tmr_byte_t io_wdata,
    output tmr_pkg::tmr_byte_t io_rdata,
    // prescaled timer clock enable
    input wire logic tick,
    // capture sources
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    // interrupt handshake, flag register layout
    input wire logic global_irq_enable,
    input wire tmr_pkg::tmr_byte_t irq_ack,
    output tmr_pkg::tmr_byte_t irq_req
);
    import tmr_pkg::*;

    // ======================================================================
    // address decoding
    // one decoder serves both the write and the read path
    function automatic tmr_sel_t tmr_decode(input tmr_addr_t a);
        case (a)
            `TMR_OFS_CNT_LO: tmr_decode = TMR_SEL_CNT_LO;
            `TMR_OFS_CNT_HI: tmr_decode = TMR_SEL_CNT_HI;
            `TMR_OFS_CTRL: tmr_decode = TMR_SEL_CTRL;
            `TMR_OFS_CMPA: tmr_decode = TMR_SEL_CMPA;
            `TMR_OFS_CMPB: tmr_decode = TMR_SEL_CMPB;
            `TMR_OFS_FLAGS: tmr_decode = TMR_SEL_FLAGS;
            `TMR_OFS_MASK: tmr_decode = TMR_SEL_MASK;
            default: tmr_decode = TMR_SEL_NONE; // unmapped reads zero
        endcase
    endfunction

    wire tmr_sel_t sel = tmr_decode(io_addr);
    wire logic wr_cnt_lo = io_wr && (sel == TMR_SEL_CNT_LO);
    wire logic wr_cnt_hi = io_wr && (sel == TMR_SEL_CNT_HI);
    wire logic wr_ctrl = io_wr && (sel == TMR_SEL_CTRL);
    wire logic wr_cmpa = io_wr && (sel == TMR_SEL_CMPA);
    wire logic wr_cmpb = io_wr && (sel == TMR_SEL_CMPB);
    wire logic wr_flags = io_wr && (sel == TMR_SEL_FLAGS);
    wire logic wr_mask = io_wr && (sel == TMR_SEL_MASK);
    wire logic rd_cnt_lo = io_rd && (sel == TMR_SEL_CNT_LO);
    wire logic rd_cmpa = io_rd && (sel == TMR_SEL_CMPA);

    // ======================================================================
    // state
    tmr_byte_t ctrl_r; // control register a
    tmr_byte_t temp_r; // shared high byte for 16-bit access
    tmr_byte_t cmpa_r; // compare a, capture low byte
    tmr_byte_t cmpb_r; // compare b, capture high byte
    tmr_byte_t flags_r; // sticky event flags
    tmr_byte_t mask_r; // interrupt enables
    tmr_byte_t rdata_r; // registered read data
    logic [15:0] cnt_r; // counter, low byte alone in 8-bit mode
    logic block_r; // compare match suppressed until next tick
    logic filt_prev_r; // filtered capture level one clock back

    // ======================================================================
    // control fields
    wire logic wide = ctrl_r[`TMR_B_WIDTH];
    wire logic capm = ctrl_r[`TMR_B_CAPEN];
    wire logic filt_en = ctrl_r[`TMR_B_FILT];
    wire logic rise_sel = ctrl_r[`TMR_B_EDGE];
    wire logic acs = ctrl_r[`TMR_B_ACS];
    wire logic ctc = ctrl_r[`TMR_B_CTC];

    // ======================================================================
    // capture front end
    // comparator replaces the pin ahead of filter and edge logic
    wire logic cap_src = acs ? comparator_out : capture_input_pin;
    logic filt_lvl;

    tmr_capture_filter #(
        .SAMPLES(FILT_SAMPLES)
    ) u_filter (
        .clk(clk),
        .rst(rst),
        .raw(cap_src),
        .filt_en(filt_en),
        .filt_out(filt_lvl)
    );

    // edge qualified by the select bit
    wire logic rise = filt_lvl && !filt_prev_r;
    wire logic fall = !filt_lvl && filt_prev_r;
    wire logic edge_evt = capm && (rise_sel ? rise : fall);

    // ======================================================================
    // compare and count
    wire logic [15:0] cmp16 = {cmpb_r, cmpa_r};
    wire logic lo_eq_a = cnt_r[7:0] == cmpa_r;
    wire logic lo_eq_b = cnt_r[7:0] == cmpb_r;
    wire logic at_top = wide ? (cnt_r == cmp16) : lo_eq_a;
    wire logic at_max = wide ? (cnt_r == 16'hFFFF) : (cnt_r[7:0] == 8'hFF);
    // in capture mode with ctc set the capture register is top, and the pin is ignored
    wire logic cap_top = capm && ctc;
    // clear-on-match obeys the same blocking as the compare flags
    wire logic clr_now = tick && ctc && at_top && !block_r;
    wire logic ovf_evt = tick && at_max && !clr_now;
    // matches are evaluated on the tick, against the value before counting
    wire logic match_a = tick && !block_r && !capm && at_top;
    wire logic match_b = tick && !block_r && !wide && lo_eq_b;
    wire logic cap_copy = edge_evt && !cap_top;
    wire logic cap_evt = cap_top ? clr_now : cap_copy;

    // increment and clear keep the high byte in 8-bit mode
    wire logic [15:0] cnt_inc = wide ? 16'(cnt_r + 16'h0001)
                                     : {cnt_r[15:8], 8'(cnt_r[7:0] + 8'h01)};
    wire logic [15:0] cnt_zero = wide ? `TMR_RST_WORD : {cnt_r[15:8], `TMR_RST_BYTE};
    // cpu write outranks counting; low write loads temp with it in 16-bit
    wire logic [15:0] cnt_nxt =
        wr_cnt_lo ? (wide ? {temp_r, io_wdata} : {cnt_r[15:8], io_wdata})
        : (wr_cnt_hi && !wide) ? {io_wdata, cnt_r[7:0]}
        : clr_now ? cnt_zero
        : tick ? cnt_inc : cnt_r;
    // any counter write arms the block; the next tick consumes it
    wire logic block_nxt = (wr_cnt_lo || wr_cnt_hi) ? 1'h1 : tick ? 1'h0 : block_r;

    // ======================================================================
    // compare registers and temp byte
    // a capture wins over a cpu write in the same clock
    wire tmr_byte_t cmpa_nxt = cap_copy ? cnt_r[7:0] : wr_cmpa ? io_wdata : cmpa_r;
    wire tmr_byte_t cmpb_nxt =
        (cap_copy && wide) ? cnt_r[15:8]
        : (wr_cmpa && wide) ? temp_r
        : (wr_cmpb && !wide) ? io_wdata : cmpb_r;
    // high byte writes park in temp; low byte reads fill it
    wire tmr_byte_t temp_nxt =
        ((wr_cnt_hi || wr_cmpb) && wide) ? io_wdata
        : (rd_cnt_lo && wide) ? cnt_r[15:8]
        : (rd_cmpa && wide && capm) ? cmpb_r : temp_r;

    // ======================================================================
    // flags and interrupt requests
    tmr_byte_t flag_set;
    always_comb begin
        flag_set = `TMR_RST_BYTE;
        flag_set[`TMR_F_CMPA] = match_a;
        flag_set[`TMR_F_CMPB] = match_b;
        flag_set[`TMR_F_OVF] = ovf_evt;
        flag_set[`TMR_F_CAP] = cap_evt;
    end
    // written ones and vector acks clear; zeros do nothing; set wins
    wire tmr_byte_t flag_clr = (wr_flags ? io_wdata : `TMR_RST_BYTE) | irq_ack;
    wire tmr_byte_t flags_nxt = ((flags_r & ~flag_clr) | flag_set) & `TMR_IRQ_MASK;
    wire tmr_byte_t mask_nxt = wr_mask ? (io_wdata & `TMR_IRQ_MASK) : mask_r;
    wire tmr_byte_t ctrl_nxt = wr_ctrl ? (io_wdata & `TMR_CTRL_WMASK) : ctrl_r;
    // requests are levels; they fall in the same clock as the flag clears
    assign irq_req = flags_r & mask_r & {8{global_irq_enable}};

    // ======================================================================
    // read path
    // the high halves read temp only where a 16-bit pair is in force
    wire tmr_byte_t rd_val =
        (sel == TMR_SEL_CNT_LO) ? cnt_r[7:0]
        : (sel == TMR_SEL_CNT_HI) ? (wide ? temp_r : cnt_r[15:8])
        : (sel == TMR_SEL_CTRL) ? ctrl_r
        : (sel == TMR_SEL_CMPA) ? cmpa_r
        : (sel == TMR_SEL_CMPB) ? ((wide && capm) ? temp_r : cmpb_r)
        : (sel == TMR_SEL_FLAGS) ? flags_r
        : (sel == TMR_SEL_MASK) ? mask_r : `TMR_RST_BYTE;
    wire tmr_byte_t rdata_nxt = io_rd ? rd_val : rdata_r;
    assign io_rdata = rdata_r;

    // ======================================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `TMR_RST_BYTE;
            temp_r <= `TMR_RST_BYTE;
            cmpa_r <= `TMR_RST_BYTE;
            cmpb_r <= `TMR_RST_BYTE;
            flags_r <= `TMR_RST_BYTE;
            mask_r <= `TMR_RST_BYTE;
            rdata_r <= `TMR_RST_BYTE;
            cnt_r <= `TMR_RST_WORD;
            block_r <= 1'h0;
            filt_prev_r <= 1'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            temp_r <= temp_nxt;
            cmpa_r <= cmpa_nxt;
            cmpb_r <= cmpb_nxt;
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            cnt_r <= cnt_nxt;
            block_r <= block_nxt;
            filt_prev_r <= filt_lvl;
        end
    end

    // ======================================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // reserved control bits never store a one
    chk_ctrl_reserved: assert property (
        ctrl_r[2:1] == 2'h0)
        else $error("reserved control bits not zero");

    // a counter write hides matches and the clear until a tick has passed
    chk_block_after_write: assert property (
        (wr_cnt_lo || wr_cnt_hi) |=> !match_a && !match_b && !clr_now)
        else $error("compare match not blocked after counter write");
    chk_block_held: assert property (
        block_r |-> !match_a && !match_b && !clr_now)
        else $error("compare match while block armed");

    // capture path: copy, flag, and the flag at top in place of the pin
    chk_capture_copy: assert property (
        cap_copy |=> cmpa_r == $past(cnt_r[7:0]) && flags_r[`TMR_F_CAP])
        else $error("capture did not copy counter or set flag");
    chk_cap_top_flag: assert property (
        cap_top && clr_now |=> flags_r[`TMR_F_CAP])
        else $error("capture flag missed at top");

    // compare flags and their gating by width and capture mode
    chk_wide_match: assert property (
        wide && match_a |-> cnt_r == {cmpb_r, cmpa_r})
        else $error("16-bit match against wrong value");
    chk_b_quiet_wide: assert property (
        wide && $past(wide) |-> !flags_r[`TMR_F_CMPB] || $past(flags_r[`TMR_F_CMPB]))
        else $error("compare b flag set in 16-bit mode");
    chk_a_quiet_cap: assert property (
        capm |-> !match_a)
        else $error("compare a matched in capture mode");

    // 16-bit pairing through the shared temp byte
    chk_temp_latch: assert property (
        rd_cnt_lo && wide |=> temp_r == $past(cnt_r[15:8]))
        else $error("low byte read did not latch high byte");
    chk_low_write_pair: assert property (
        wr_cnt_lo && wide |=> cnt_r == {$past(temp_r), $past(io_wdata)})
        else $error("16-bit counter write not paired with temp");
    chk_cmp_pair_load: assert property (
        wr_cmpa && wide && !cap_copy |=> cmpb_r == $past(temp_r))
        else $error("16-bit compare write not paired with temp");

    // flags, their clears and the request gate
    chk_irq_gate: assert property (
        irq_req[`TMR_F_OVF] |-> global_irq_enable && mask_r[`TMR_F_OVF] && flags_r[`TMR_F_OVF])
        else $error("overflow request without enable");
    chk_flag_clear: assert property (
        wr_flags && io_wdata[`TMR_F_OVF] && !ovf_evt |=> !flags_r[`TMR_F_OVF])
        else $error("overflow flag survived a written one");
    chk_flag_keep: assert property (
        wr_flags && io_wdata == 8'h00 && irq_ack == 8'h00
        |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("writing zero cleared a flag");
    chk_ovf_set: assert property (
        ovf_evt |=> flags_r[`TMR_F_OVF])
        else $error("overflow without flag");

    // counting sequence
    chk_ctc_clear: assert property (
        clr_now && !wr_cnt_lo && !wr_cnt_hi |=> cnt_r[7:0] == 8'h00)
        else $error("clear on match did not zero counter");

    // main scenarios; the capture one wants a cpu read soon after it
    cov_capture: cover property (cap_copy ##[1:40] rd_cmpa);
    cov_wide_match: cover property (wide && match_a);
    cov_blocked: cover property (block_r && tick && at_top);
    cov_cap_top: cover property (cap_top && cap_evt);
endmodule
`default_nettype wire

// File: hdl/tmr_params.svh
// register offsets, field positions, reset values and counts of the timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ==========================================================================
// io port geometry
`define TMR_ADDR_W 6

// ==========================================================================
// register offsets on the io port
`define TMR_OFS_CNT_LO 6'h12
`define TMR_OFS_CNT_HI 6'h14
`define TMR_OFS_CTRL 6'h15
`define TMR_OFS_CMPA 6'h16
`define TMR_OFS_CMPB 6'h17
`define TMR_OFS_FLAGS 6'h38
`define TMR_OFS_MASK 6'h39

// ==========================================================================
// control register a fields
`define TMR_B_WIDTH 7
`define TMR_B_CAPEN 6
`define TMR_B_FILT 5
`define TMR_B_EDGE 4
`define TMR_B_ACS 3
`define TMR_B_CTC 0
`define TMR_CTRL_WMASK 8'hF9

// ==========================================================================
// flag and mask fields (same layout in both registers)
`define TMR_F_CMPA 4
`define TMR_F_CMPB 3
`define TMR_F_OVF 1
`define TMR_F_CAP 0
`define TMR_IRQ_MASK 8'h1B

// ==========================================================================
// reset values and counts
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_FILT_SAMPLES 4

`endif

// File: hdl/tmr_pkg.sv
// types shared by the timer design files
`include "tmr_params.svh"

package tmr_pkg;
    // one byte of the cpu data bus
    typedef logic [7:0] tmr_byte_t;
    // io port address
    typedef logic [`TMR_ADDR_W-1:0] tmr_addr_t;
    // decoded register selection
    typedef enum logic [2:0] {
        TMR_SEL_NONE,
        TMR_SEL_CNT_LO,
        TMR_SEL_CNT_HI,
        TMR_SEL_CTRL,
        TMR_SEL_CMPA,
        TMR_SEL_CMPB,
        TMR_SEL_FLAGS,
        TMR_SEL_MASK
    } tmr_sel_t;
endpackage

// File: hdl/tmr_capture_filter.sv
// capture input noise filter: output follows after n equal samples
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_capture_filter #(
    parameter int SAMPLES = `TMR_FILT_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw sample and filter switch
    input wire logic raw,
    input wire logic filt_en,
    // filtered level
    output logic filt_out
);
    import tmr_pkg::*;

    // ======================================================================
    // sample history
    logic [SAMPLES-1:0] hist_r; // newest sample in bit 0
    wire logic all_hi = &hist_r;
    wire logic all_lo = ~|hist_r;

    // shift in every clock; with the filter on, output moves only on a unanimous history
    always_ff @(posedge clk) begin
        if (rst) begin
            hist_r <= '0;
            filt_out <= 1'h0;
        end else begin
            hist_r <= {hist_r[SAMPLES-2:0], raw};
            if (!filt_en) begin
                filt_out <= raw; // bypass, one register stage only
            end else if (all_hi) begin
                filt_out <= 1'h1;
            end else if (all_lo) begin
                filt_out <= 1'h0;
            end
        end
    end

    // ======================================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_filter_rise: assert property (
        filt_en && $past(filt_en) && $rose(filt_out) |-> $past(all_hi))
        else $error("filter rose without four high samples");
    chk_filter_fall: assert property (
        filt_en && $past(filt_en) && $fell(filt_out) |-> $past(all_lo))
        else $error("filter fell without four low samples");
endmodule
`default_nettype wire

// File: tb/tmr_cpu_model.sv
// cpu partner model: drives the timer io port one access at a time
`timescale 1ns/1ps
`default_nettype none

module tmr_cpu_model (
    // clock
    input wire logic clk,
    // io port towards the timer
    output tmr_pkg::tmr_addr_t io_addr,
    output logic io_wr,
    output logic io_rd,
    output tmr_pkg::tmr_byte_t io_wdata,
    input wire tmr_pkg::tmr_byte_t io_rdata
);
    import tmr_pkg::*;

    // ======================================================================
    // idle bus
    initial begin
        io_addr = 6'h00;
        io_wr = 1'h0;
        io_rd = 1'h0;
        io_wdata = 8'h00;
    end

    // ======================================================================
    // single byte accesses
    // one strobe cycle; address and data flip when released, so a stale
    // value can never pass for a held one
    task automatic wr(input tmr_addr_t a, input tmr_byte_t d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'h1;
        @(posedge clk);
        io_wr <= 1'h0;
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask

    // read data is loaded on the edge that takes the strobe
    task automatic rd(input tmr_addr_t a, output tmr_byte_t d);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'h1;
        @(posedge clk);
        io_rd <= 1'h0;
        io_addr <= ~a;
        @(negedge clk);
        d = io_rdata;
    endtask

    // ======================================================================
    // word accesses through the shared temp byte
    task automatic wr16(input tmr_addr_t ah, input tmr_addr_t al, input logic [15:0] v);
        wr(ah, v[15:8]);
        wr(al, v[7:0]);
    endtask

    task automatic rd16(input tmr_addr_t al, input tmr_addr_t ah, output logic [15:0] v);
        rd(al, v[7:0]);
        rd(ah, v[15:8]);
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking testbench of the timer register block
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tb_top;
    import tmr_pkg::*;

    // ======================================================================
    // signals
    logic clk;
    logic rst;
    logic tick;
    logic capture_input_pin;
    logic comparator_out;
    logic global_irq_enable;
    tmr_byte_t irq_ack;
    tmr_byte_t irq_req;
    tmr_addr_t io_addr;
    logic io_wr;
    logic io_rd;
    tmr_byte_t io_wdata;
    tmr_byte_t io_rdata;
    // bookkeeping
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] w;
    // run takes well under this many cycles
    localparam int LIMIT = 6000;
    // counter, control, flag and mask registers read zero after reset, and so does an unmapped place
    localparam tmr_addr_t ZERO_ADDRS [6] = '{`TMR_OFS_CNT_LO, `TMR_OFS_CNT_HI,
        `TMR_OFS_CTRL, `TMR_OFS_FLAGS, `TMR_OFS_MASK, 6'h3F};
    // capture cases: control, comparator as source, pulse width, flags;
    // the last one is 16-bit capture and runs on its own
    localparam tmr_byte_t CAP_CTRL [8] = '{8'h50, 8'h40, 8'h70, 8'h70,
        8'h58, 8'h58, 8'h10, 8'hD0};
    localparam logic CAP_CMP [8] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
    localparam int CAP_W [8] = '{6, 6, 3, 6, 6, 6, 6, 6};
    localparam tmr_byte_t CAP_EXP [8] = '{8'h01, 8'h01, 8'h00, 8'h01,
        8'h00, 8'h01, 8'h00, 8'h01};

    // ======================================================================
    // design and cpu partner
    tmr_timer dut_u (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .tick(tick),
        .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
        .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq_req(irq_req));
    tmr_cpu_model cpu_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    // ======================================================================
    // clock and hang guard
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            conclude();
        end
    end

    // ======================================================================
    // helpers
    task automatic check(input tmr_byte_t seen, input tmr_byte_t exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input tmr_addr_t a, input tmr_byte_t exp);
        tmr_byte_t d;
        cpu_u.rd(a, d);
        check(d, exp);
    endtask

    // exactly n timer ticks, then the prescaler stops
    task automatic run_ticks(input int n);
        @(posedge clk);
        tick <= 1'h1;
        repeat (n) @(posedge clk);
        tick <= 1'h0;
    endtask

    // one pulse on the chosen source, then the capture flag is read
    task automatic cap_try(input int i);
        cpu_u.wr(`TMR_OFS_CTRL, CAP_CTRL[i]);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        @(posedge clk);
        comparator_out <= CAP_CMP[i];
        capture_input_pin <= !CAP_CMP[i];
        repeat (CAP_W[i]) @(posedge clk);
        comparator_out <= 1'h0;
        capture_input_pin <= 1'h0;
        repeat (8) @(posedge clk);
        rdchk(`TMR_OFS_FLAGS, CAP_EXP[i]);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ======================================================================
    // test sequence
    initial begin
        rst = 1'h1;
        tick = 1'h0;
        capture_input_pin = 1'h0;
        comparator_out = 1'h0;
        global_irq_enable = 1'h0;
        irq_ack = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        foreach (ZERO_ADDRS[i]) rdchk(ZERO_ADDRS[i], 8'h00);
        cpu_u.wr(`TMR_OFS_CTRL, 8'hFF);
        rdchk(`TMR_OFS_CTRL, 8'hF9);
        $display("test reset done");
        // word access: a lone high write only reaches temp
        cpu_u.wr(`TMR_OFS_CTRL, 8'h80);
        cpu_u.wr16(`TMR_OFS_CNT_HI, `TMR_OFS_CNT_LO, 16'h1234);
        cpu_u.wr(`TMR_OFS_CNT_HI, 8'h77);
        cpu_u.rd16(`TMR_OFS_CNT_LO, `TMR_OFS_CNT_HI, w);
        check(w[7:0], 8'h34);
        check(w[15:8], 8'h12);
        cpu_u.wr16(`TMR_OFS_CMPB, `TMR_OFS_CMPA, 16'hABCD);
        cpu_u.wr(`TMR_OFS_CNT_HI, 8'h55);
        rdchk(`TMR_OFS_CMPB, 8'hAB);
        rdchk(`TMR_OFS_CMPA, 8'hCD);
        cpu_u.wr(`TMR_OFS_CTRL, 8'h00);
        cpu_u.wr(`TMR_OFS_CNT_HI, 8'h09);
        rdchk(`TMR_OFS_CNT_HI, 8'h09);
        $display("test access done");
        // a counter write hides the match on the next tick only
        cpu_u.wr(`TMR_OFS_CMPA, 8'h05);
        cpu_u.wr(`TMR_OFS_CNT_LO, 8'h05);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        run_ticks(1);
        rdchk(`TMR_OFS_FLAGS, 8'h00);
        rdchk(`TMR_OFS_CNT_LO, 8'h06);
        cpu_u.wr(`TMR_OFS_CMPA, 8'h06);
        run_ticks(1);
        rdchk(`TMR_OFS_FLAGS, 8'h10);
        $display("test blocking done");
        // overflow, request gating and vector clear
        cpu_u.wr(`TMR_OFS_CMPA, 8'h10);
        cpu_u.wr(`TMR_OFS_CMPB, 8'h10);
        cpu_u.wr(`TMR_OFS_CNT_LO, 8'hFE);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        cpu_u.wr(`TMR_OFS_MASK, 8'hFF);
        rdchk(`TMR_OFS_MASK, 8'h1B);
        @(posedge clk);
        global_irq_enable <= 1'h1;
        run_ticks(3);
        rdchk(`TMR_OFS_FLAGS, 8'h02);
        check(irq_req, 8'h02);
        rdchk(`TMR_OFS_CNT_HI, 8'h09);
        @(posedge clk);
        global_irq_enable <= 1'h0;
        @(negedge clk);
        check(irq_req, 8'h00);
        @(posedge clk);
        irq_ack <= 8'h02;
        @(posedge clk);
        irq_ack <= 8'h00;
        rdchk(`TMR_OFS_FLAGS, 8'h00);
        $display("test overflow done");
        // 8-bit clear on match, flag write of zeros keeps the flag
        cpu_u.wr(`TMR_OFS_CTRL, 8'h01);
        cpu_u.wr(`TMR_OFS_CMPA, 8'h03);
        cpu_u.wr(`TMR_OFS_CMPB, 8'h80);
        cpu_u.wr(`TMR_OFS_CNT_LO, 8'h00);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        run_ticks(6);
        rdchk(`TMR_OFS_CNT_LO, 8'h02);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'h0F);
        rdchk(`TMR_OFS_FLAGS, 8'h10);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'h10);
        rdchk(`TMR_OFS_FLAGS, 8'h00);
        $display("test clear on match done");
        // 16-bit clear on match; low byte of counter equals compare b
        cpu_u.wr(`TMR_OFS_CTRL, 8'h81);
        cpu_u.wr16(`TMR_OFS_CMPB, `TMR_OFS_CMPA, 16'h0102);
        cpu_u.wr16(`TMR_OFS_CNT_HI, `TMR_OFS_CNT_LO, 16'h0100);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        run_ticks(4);
        cpu_u.rd16(`TMR_OFS_CNT_LO, `TMR_OFS_CNT_HI, w);
        check(w[7:0], 8'h01);
        check(w[15:8], 8'h00);
        rdchk(`TMR_OFS_FLAGS, 8'h10);
        $display("test wide compare done");
        // capture front end
        cpu_u.wr(`TMR_OFS_CTRL, 8'h00);
        cpu_u.wr(`TMR_OFS_CNT_LO, 8'h42);
        for (int i = 0; i < 7; i++) cap_try(i);
        rdchk(`TMR_OFS_CMPA, 8'h42);
        // capture register as top: flag at top, not compare a;
        // compare b still holds 01 and matches in 8-bit use
        cpu_u.wr(`TMR_OFS_CTRL, 8'h41);
        cpu_u.wr(`TMR_OFS_CMPA, 8'h02);
        cpu_u.wr(`TMR_OFS_CNT_LO, 8'h00);
        cpu_u.wr(`TMR_OFS_FLAGS, 8'hFF);
        run_ticks(4);
        rdchk(`TMR_OFS_FLAGS, 8'h09);
        $display("test capture done");
        // 16-bit capture: the high half answers from temp, latched by the low read
        cpu_u.wr(`TMR_OFS_CTRL, 8'hD0);
        cpu_u.wr16(`TMR_OFS_CMPB, `TMR_OFS_CMPA, 16'h5A3C);
        rdchk(`TMR_OFS_CMPA, 8'h3C);
        cap_try(7);
        rdchk(`TMR_OFS_CMPB, 8'h5A);
        cpu_u.rd16(`TMR_OFS_CMPA, `TMR_OFS_CMPB, w);
        check(w[7:0], 8'h01);
        check(w[15:8], 8'h00);
        $display("test wide capture done");
        conclude();
    end
endmodule
`default_nettype wire
